// ### tpwm_defines.svh
// Register offsets, field positions, reset values and timing counts of the three-phase modulator.
`ifndef TPWM_DEFINES_SVH
`define TPWM_DEFINES_SVH

`define TPWM_ADDR_W          8
`define TPWM_IDX_DUTY_HIGH   8'h1a
`define TPWM_IDX_DUTY_LOW    8'h1b
`define TPWM_IDX_CONTROL     8'h1c
`define TPWM_IDX_PORT_DATA   8'h1d
`define TPWM_IDX_PORT_DIR    8'h1e
`define TPWM_IDX_STATUS      8'h1f

`define TPWM_CTL_TRUE_EN     0
`define TPWM_CTL_COMP_EN     1
`define TPWM_CTL_DT_EN       2
`define TPWM_CTL_PS_LSB      3
`define TPWM_CTL_PS_MSB      5
`define TPWM_CTL_DT_LSB      6
`define TPWM_CTL_DT_MSB      7

`define TPWM_SEL_HI          7
`define TPWM_SEL_LO          6

`define TPWM_CONTROL_RESET   8'h00
`define TPWM_PORT_DATA_RESET 8'h00
`define TPWM_PORT_DIR_RESET  8'hff
`define TPWM_DUTY_RESET      10'h000

`define TPWM_CYCLE_CLOCKS    11'h400
`define TPWM_DT_BASE_CLOCKS  5'h02

`endif

// ### tpwm_pkg.sv
// Types shared by the three-phase modulator.
package tpwm_pkg;

    typedef enum logic [1:0] {
        TPWM_MODE_STD,
        TPWM_MODE_9P1,
        TPWM_MODE_8P2,
        TPWM_MODE_7P3
    } tpwm_mode_t;

    typedef struct packed {
        logic [2:0] drive;
        logic [2:0] enable;
    } tpwm_pins_t;

endpackage : tpwm_pkg

// ### tpwm_core.sv
// Three-phase modulator with complementary outputs, dead time and an Avalon-MM register slave.
//
// Overview of operation
// - Writing low duty only fills a two-bit holding buffer.
// - Duty is high byte bits 9..2 plus low bits 1..0.
// - True pin passes waveform when latch is 1, else inactive level.
// - Complement pin passes waveform when latch is 1, else inactive level.
// - Standard, 9+1, 8+2 and 7+3 modes chosen by a fixed option.
// - Counter runs on prescaled clock; full cycle is 1024 ticks always.
// - Prescaler and duty registers may be written at any time.
// - 9+1 mode: two 512-tick modulation cycles, nine coarse, one fine bit.
// - 8+2 mode: four 256-tick modulation cycles, high byte coarse.
// - 7+3 mode: eight 128-tick modulation cycles, three fine bits.
// - Modulation cycle below fine value is active one tick longer.
// - Standard mode: one 1024-tick cycle active for the whole duty value.
// - True enable plus select bits pick channel 0, 1, 2 or all.
// - Complement enable uses the same selection, independent of true enable.
// - A period request pulses at each counter overflow.
// - Complement output offers optional dead time of 2 to 16 clocks.
// - Control bits 5..3 divide system clock by 1 to 128.
// - Control bits 7..6 pick 2, 4, 8 or 16 clocks; a bit enables it.
// - True polarity option 0 is active high, 1 is active low.
// - Complement polarity option 0 is active high, 1 is active low.
`timescale 1ns/100ps
`include "tpwm_defines.svh"

module tpwm_core
    import tpwm_pkg::*;
#(
    parameter tpwm_mode_t MODE             = TPWM_MODE_STD,
    parameter logic       TRUE_POLARITY    = 1'b0,
    parameter logic       COMP_POLARITY    = 1'b0
) (
    input  wire logic                     sys_clk,
    input  wire logic                     reset_n,
    input  wire logic [`TPWM_ADDR_W-1:0]  avs_address,
    input  wire logic                     avs_read,
    input  wire logic                     avs_write,
    input  wire logic [31:0]              avs_writedata,
    input  wire logic [3:0]               avs_byteenable,
    output      logic [31:0]              avs_readdata,
    output      logic                     avs_waitrequest,
    output      tpwm_pins_t               true_pins,
    output      tpwm_pins_t               comp_pins,
    output      logic                     period_irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register slave.

    logic [7:0] duty_high_byte_reg;
    logic [1:0] duty_low_bits_reg;
    logic [9:0] duty_active_reg;
    logic [7:0] modulator_control_reg;
    logic [7:0] port_data_reg;
    logic [7:0] port_direction_control_reg;
    logic       ack_reg;
    logic       overflow_seen_reg;
    logic [9:0] count_reg;
    logic       tick;
    logic       period_end;
    logic       wr_low;
    logic       access;

    // Every access takes one wait cycle, so read data always comes from a flop.
    assign access          = avs_read | avs_write;
    assign avs_waitrequest = access & ~ack_reg;
    assign wr_low          = avs_write & ack_reg & avs_byteenable[0];

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= access & ~ack_reg;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            duty_high_byte_reg <= 8'h00;
            duty_low_bits_reg  <= 2'h0;
        end else if (wr_low) begin
            case (avs_address)
                `TPWM_IDX_DUTY_LOW: begin
                    duty_low_bits_reg <= avs_writedata[1:0];
                end
                `TPWM_IDX_DUTY_HIGH: begin
                    duty_high_byte_reg <= avs_writedata[7:0];
                end
                default: ;
            endcase
        end
    end

    // The pending duty is loaded only on the high-byte write, so both halves land together; it is committed at the period end.
    logic [9:0] duty_pending_reg;
    logic       duty_loaded_reg;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            duty_pending_reg <= `TPWM_DUTY_RESET;
            duty_loaded_reg  <= 1'b0;
        end else if (wr_low && avs_address == `TPWM_IDX_DUTY_HIGH) begin
            duty_pending_reg <= {avs_writedata[7:0], duty_low_bits_reg};
            duty_loaded_reg  <= 1'b1;
        end else if (period_end) begin
            duty_loaded_reg  <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            duty_active_reg <= `TPWM_DUTY_RESET;
        end else if (period_end && duty_loaded_reg) begin
            duty_active_reg <= duty_pending_reg;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            modulator_control_reg      <= `TPWM_CONTROL_RESET;
            port_data_reg              <= `TPWM_PORT_DATA_RESET;
            port_direction_control_reg <= `TPWM_PORT_DIR_RESET;
        end else if (wr_low) begin
            case (avs_address)
                `TPWM_IDX_CONTROL:   modulator_control_reg      <= avs_writedata[7:0];
                `TPWM_IDX_PORT_DATA: port_data_reg              <= avs_writedata[7:0];
                `TPWM_IDX_PORT_DIR:  port_direction_control_reg <= avs_writedata[7:0];
                default: ;
            endcase
        end
    end

    // Overflow flag: set wins over a same-cycle read clear.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            overflow_seen_reg <= 1'b0;
        end else if (period_end) begin
            overflow_seen_reg <= 1'b1;
        end else if (avs_read && ack_reg && avs_address == `TPWM_IDX_STATUS) begin
            overflow_seen_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ack_reg) begin
            case (avs_address)
                `TPWM_IDX_DUTY_HIGH: avs_readdata <= {24'h000000, duty_high_byte_reg};
                `TPWM_IDX_DUTY_LOW:  avs_readdata <= {30'h0, duty_low_bits_reg};
                `TPWM_IDX_CONTROL:   avs_readdata <= {24'h000000, modulator_control_reg};
                `TPWM_IDX_PORT_DATA: avs_readdata <= {24'h000000, port_data_reg};
                `TPWM_IDX_PORT_DIR:  avs_readdata <= {24'h000000, port_direction_control_reg};
                `TPWM_IDX_STATUS:    avs_readdata <= {22'h0, count_reg};
                default:             avs_readdata <= {29'h0, COMP_POLARITY, TRUE_POLARITY, overflow_seen_reg};
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Prescaler and cycle counter.

    logic [6:0] prescale_reg;
    logic [2:0] prescale_sel;
    logic [6:0] prescale_mask;

    assign prescale_sel  = modulator_control_reg[`TPWM_CTL_PS_MSB:`TPWM_CTL_PS_LSB];
    // A mask compare lets the rate change mid-run without a reload glitch.
    assign prescale_mask = 7'((8'h01 << prescale_sel) - 8'h01);
    assign tick          = (prescale_reg & prescale_mask) == prescale_mask;
    assign period_end    = tick && (count_reg == 10'h3ff);

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            prescale_reg <= 7'h00;
        end else begin
            prescale_reg <= prescale_reg + 7'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            count_reg <= 10'h000;
        end else if (tick) begin
            count_reg <= count_reg + 10'h001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            period_irq <= 1'b0;
        end else begin
            period_irq <= period_end;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Waveform.

    // Returns whether the current tick lies in the active part of its modulation cycle.
    function automatic logic wave_active(input tpwm_mode_t m, input logic [9:0] d, input logic [9:0] c);
        logic [9:0] coarse_duty;
        logic [2:0] fine_duty;
        logic [9:0] pos;
        logic [2:0] idx;
        coarse_duty = 10'h000;
        fine_duty   = 3'h0;
        pos         = c;
        idx         = 3'h0;
        case (m)
            TPWM_MODE_9P1: begin
                coarse_duty = {1'b0, d[9:1]};
                fine_duty   = {2'b00, d[0]};
                pos         = {1'b0, c[8:0]};
                idx         = {2'b00, c[9]};
            end
            TPWM_MODE_8P2: begin
                coarse_duty = {2'b00, d[9:2]};
                fine_duty   = {1'b0, d[1:0]};
                pos         = {2'b00, c[7:0]};
                idx         = {1'b0, c[9:8]};
            end
            TPWM_MODE_7P3: begin
                coarse_duty = {3'b000, d[9:3]};
                fine_duty   = d[2:0];
                pos         = {3'b000, c[6:0]};
                idx         = c[9:7];
            end
            default: begin
                coarse_duty = d;
            end
        endcase
        if (m != TPWM_MODE_STD && idx < fine_duty) begin
            wave_active = pos <= coarse_duty;
        end else begin
            wave_active = pos < coarse_duty;
        end
    endfunction : wave_active

    logic wave_reg;
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            wave_reg <= 1'b0;
        end else begin
            wave_reg <= wave_active(MODE, duty_active_reg, count_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Dead time and pin drive.

    logic [4:0] dt_count_reg;
    logic       wave_prev_reg;
    logic       true_wave;
    logic       comp_wave;
    logic [4:0] dt_len;
    logic       dt_on;

    assign dt_on  = modulator_control_reg[`TPWM_CTL_DT_EN];
    assign dt_len = 5'(`TPWM_DT_BASE_CLOCKS << modulator_control_reg[`TPWM_CTL_DT_MSB:`TPWM_CTL_DT_LSB]);

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            wave_prev_reg <= 1'b0;
            dt_count_reg  <= 5'h00;
        end else begin
            wave_prev_reg <= wave_reg;
            if (wave_reg != wave_prev_reg) begin
                dt_count_reg <= dt_len - 5'h01;
            end else if (dt_count_reg != 5'h00) begin
                dt_count_reg <= dt_count_reg - 5'h01;
            end
        end
    end

    // The edge cycle itself is blanked, so neither side can switch on in the cycle the other switches off.
    assign true_wave = wave_reg & ~(dt_on && (wave_reg != wave_prev_reg || dt_count_reg != 5'h00));
    assign comp_wave = ~wave_reg & ~(dt_on && (wave_reg != wave_prev_reg || dt_count_reg != 5'h00));

    function automatic logic [2:0] channel_mask(input logic en, input logic [1:0] sel);
        channel_mask = 3'h0;
        if (en) begin
            case (sel)
                2'b00:   channel_mask = 3'b001;
                2'b01:   channel_mask = 3'b010;
                2'b10:   channel_mask = 3'b100;
                default: channel_mask = 3'b111;
            endcase
        end
    endfunction : channel_mask

    logic [1:0] channel_sel;
    logic [2:0] true_sel;
    logic [2:0] comp_sel;
    assign channel_sel = {port_data_reg[`TPWM_SEL_HI], port_data_reg[`TPWM_SEL_LO]};
    assign true_sel    = channel_mask(modulator_control_reg[`TPWM_CTL_TRUE_EN], channel_sel);
    assign comp_sel    = channel_mask(modulator_control_reg[`TPWM_CTL_COMP_EN], channel_sel);

    // Deselected pins fall back to the plain port latch.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            true_pins <= '0;
            comp_pins <= '0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                true_pins.enable[i] <= ~port_direction_control_reg[2*i];
                comp_pins.enable[i] <= ~port_direction_control_reg[2*i+1];
                true_pins.drive[i]  <= true_sel[i] ? ((port_data_reg[2*i] & true_wave) ^ TRUE_POLARITY)
                                                   : port_data_reg[2*i];
                comp_pins.drive[i]  <= comp_sel[i] ? ((port_data_reg[2*i+1] & comp_wave) ^ COMP_POLARITY)
                                                   : port_data_reg[2*i+1];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    property p_period;
        @(posedge sys_clk) disable iff (!reset_n) period_end |=> period_irq ##1 !period_irq;
    endproperty
    a_period: assert property (p_period) else $error("period request not a single pulse");

    property p_wrap;
        @(posedge sys_clk) disable iff (!reset_n) period_end |=> count_reg == 10'h000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap");

    property p_commit;
        @(posedge sys_clk) disable iff (!reset_n)
            (period_end && duty_loaded_reg) |=> duty_active_reg == $past(duty_pending_reg);
    endproperty
    a_commit: assert property (p_commit) else $error("duty not committed at cycle end");

    property p_hold;
        @(posedge sys_clk) disable iff (!reset_n) !period_end |=> $stable(duty_active_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("duty changed mid cycle");

    property p_low_buf;
        @(posedge sys_clk) disable iff (!reset_n)
            (wr_low && avs_address == `TPWM_IDX_DUTY_LOW) |=> $stable(duty_pending_reg);
    endproperty
    a_low_buf: assert property (p_low_buf) else $error("low write reached pending duty");

    property p_no_overlap;
        @(posedge sys_clk) disable iff (!reset_n) dt_on |-> !(true_wave && comp_wave);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("true and complement active together");

    property p_complement;
        @(posedge sys_clk) disable iff (!reset_n) !dt_on |-> comp_wave == !true_wave;
    endproperty
    a_complement: assert property (p_complement) else $error("complement not inverse");

    property p_disable;
        @(posedge sys_clk) disable iff (!reset_n) !modulator_control_reg[`TPWM_CTL_TRUE_EN] |-> true_sel == 3'h0;
    endproperty
    a_disable: assert property (p_disable) else $error("true output selected while disabled");

    property p_tick_div1;
        @(posedge sys_clk) disable iff (!reset_n) prescale_sel == 3'h0 |-> tick;
    endproperty
    a_tick_div1: assert property (p_tick_div1) else $error("undivided prescaler missed a tick");

endmodule : tpwm_core

// ### tpwm_gate_model.sv
// Power-stage gate driver model that counts cycles with both switches of a leg on.
`timescale 1ns/100ps
module tpwm_gate_model
    import tpwm_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire tpwm_pins_t high_side,
    input  wire tpwm_pins_t low_side,
    output int              shoot_cnt
);
    logic [2:0] on_high;
    logic [2:0] on_low;
    logic [2:0] high_prev;
    logic [2:0] low_prev;

    ////////////////////////////////////////////////////////////////////////////////
    // Both switches of one leg on at once shorts the supply, so every such cycle is counted.
    assign on_high = high_side.drive & high_side.enable;
    assign on_low  = low_side.drive & low_side.enable;
    // A leg that hands over from one switch to the other with no idle cycle between counts as well.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            shoot_cnt <= 0;
            high_prev <= 3'h0;
            low_prev  <= 3'h0;
        end else begin
            high_prev <= on_high;
            low_prev  <= on_low;
            if (((on_high & (on_low | low_prev)) | (on_low & high_prev)) != 3'h0) begin
                shoot_cnt <= shoot_cnt + 1;
            end
        end
    end
endmodule : tpwm_gate_model

// ### test_three_phase_pwm_with_complement.sv
// Self-checking testbench of the three-phase modulator.
`timescale 1ns/100ps
`include "tpwm_defines.svh"
module test_three_phase_pwm_with_complement
    import tpwm_pkg::*;
;
    logic        sys_clk;
    logic        reset_n;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        period_irq;
    tpwm_pins_t  true_pins;
    tpwm_pins_t  comp_pins;
    tpwm_pins_t  split_pins[3];
    int          shoot_cnt;
    int          error_cnt;
    int          samples_checked;
    int          per;
    int          blo[3];
    int          bedge[3];
    int          shoot0;
    int          thi[3];
    int          chi[3];
    int          duty;
    logic [31:0] rd;

    ////////////////////////////////////////////////////////////////////////////////
    tpwm_core tpwm_core_i (.sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .true_pins(true_pins), .comp_pins(comp_pins), .period_irq(period_irq));
    // One split instance per split mode shares the bus; only each phase 0 true pin is watched.
    for (genvar k = 0; k < 3; k++) begin : g_split
        tpwm_core #(.MODE(tpwm_mode_t'(k + 1)), .TRUE_POLARITY(1'b1)) tpwm_core_i (.sys_clk(sys_clk),
            .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
            .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(),
            .avs_waitrequest(), .true_pins(split_pins[k]), .comp_pins(), .period_irq());
    end
    tpwm_gate_model tpwm_gate_model_i (.sys_clk(sys_clk), .reset_n(reset_n), .high_side(true_pins),
        .low_side(comp_pins), .shoot_cnt(shoot_cnt));

    always #12.5 sys_clk = ~sys_clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    // Request is held until waitrequest is sampled low; read data is taken at that edge.
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] val, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address    <= idx;
        avs_write      <= wr;
        avs_read       <= !wr;
        avs_writedata  <= {24'h0, val};
        avs_byteenable <= be;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 16);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (n >= 16) begin
            check("bus answer", 32'h1, 32'h0);
            final_report();
        end
    endtask : bus

    task automatic set_duty(input int d);
        bus(1'b1, `TPWM_IDX_DUTY_LOW, {6'h0, d[1:0]}, 4'h1);
        bus(1'b1, `TPWM_IDX_DUTY_HIGH, d[9:2], 4'h1);
    endtask : set_duty

    task automatic wait_irq();
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (period_irq !== 1'b1 && n < 20000);
        if (n >= 20000) begin
            check("period request", 32'h0, 32'h1);
            final_report();
        end
    endtask : wait_irq

    // Counts active cycles of every main-instance pin and of each split phase 0 true pin over one full period, from one period request to the next.
    task automatic measure();
        logic [2:0] prev_b;
        wait_irq();
        per = 0;
        blo = '{0, 0, 0};
        bedge = '{0, 0, 0};
        shoot0 = shoot_cnt;
        thi = '{0, 0, 0};
        chi = '{0, 0, 0};
        prev_b = {split_pins[2].drive[0], split_pins[1].drive[0], split_pins[0].drive[0]};
        do begin
            @(posedge sys_clk);
            per++;
            for (int c = 0; c < 3; c++) begin
                thi[c] += true_pins.drive[c];
                chi[c] += comp_pins.drive[c];
                blo[c] += !split_pins[c].drive[0];
                bedge[c] += (prev_b[c] && !split_pins[c].drive[0]);
                prev_b[c] = split_pins[c].drive[0];
            end
        end while (period_irq !== 1'b1 && per < 20000);
        shoot0 = shoot_cnt - shoot0;
        if (per >= 20000) begin
            check("period end", 32'h0, 32'h1);
            final_report();
        end
    endtask : measure

    function automatic int dt_len(input int en, input int sel);
        return en ? (2 << sel) : 0;
    endfunction : dt_len

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        reset_n = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        error_cnt = 0;
        samples_checked = 0;
        void'($urandom(68149));
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        check("enable after reset", true_pins.enable, 3'h0);
        bus(1'b0, `TPWM_IDX_CONTROL, 8'h00, 4'h1);
        check("control reset", rd, `TPWM_CONTROL_RESET);
        bus(1'b0, `TPWM_IDX_PORT_DIR, 8'h00, 4'h1);
        check("direction reset", rd, `TPWM_PORT_DIR_RESET);
        bus(1'b1, `TPWM_IDX_PORT_DIR, 8'h00, 4'h1);
        duty = $urandom_range(200, 800);
        set_duty(duty);
        bus(1'b0, `TPWM_IDX_DUTY_HIGH, 8'h00, 4'h1);
        check("duty high readback", rd, duty >> 2);
        for (int s = 0; s < 4; s++) begin
            bus(1'b1, `TPWM_IDX_PORT_DATA, {s[1:0], 6'h3f}, 4'h1);
            bus(1'b1, `TPWM_IDX_CONTROL, 8'h03, 4'h1);
            measure();
            check("pin enables", {comp_pins.enable, true_pins.enable}, 6'h3f);
            check("cycle length", per, 1024);
            for (int c = 0; c < 3; c++) begin
                check("true active", thi[c], (s == 3 || s == c) ? duty : per);
                check("comp active", chi[c], (s == 3 || s == c) ? 1024 - duty : per);
            end
            if (s == 0 || s == 3) begin
                for (int k = 0; k < 3; k++) begin
                    check("split active low", blo[k], duty);
                    check("split activations", bedge[k], 2 << k);
                end
            end
        end
        bus(1'b1, `TPWM_IDX_CONTROL, 8'h02, 4'h1);
        measure();
        check("true disabled", thi[2], per);
        check("comp without true", chi[2], 1024 - duty);
        bus(1'b1, `TPWM_IDX_CONTROL, 8'hff, 4'h0);
        bus(1'b0, `TPWM_IDX_CONTROL, 8'h00, 4'h1);
        check("write without lane", rd, 32'h02);
        bus(1'b1, `TPWM_IDX_CONTROL, 8'h03, 4'h1);
        bus(1'b1, `TPWM_IDX_PORT_DATA, 8'hfc, 4'h1);
        measure();
        check("true latch low", thi[0], 0);
        check("comp latch low", chi[0], 0);
        check("other channel", thi[1], duty);
        bus(1'b1, `TPWM_IDX_DUTY_LOW, {6'h0, ~duty[1:0]}, 4'h1);
        measure();
        check("low write alone", thi[1], duty);
        bus(1'b1, `TPWM_IDX_DUTY_HIGH, duty[9:2], 4'h1);
        duty = {duty[9:2], ~duty[1:0]};
        measure();
        check("buffered commit", thi[1], duty);
        for (int t = 0; t < 4; t++) begin
            duty = $urandom_range(100, 900);
            set_duty(duty);
            bus(1'b1, `TPWM_IDX_CONTROL, {t[1:0], 6'h07}, 4'h1);
            measure();
            check("dead true", thi[1], duty - dt_len(1, t));
            check("dead comp", chi[1], 1024 - duty - dt_len(1, t));
            check("shoot through", shoot0, 0);
        end
        for (int p = 1; p < 3; p++) begin
            duty = $urandom_range(100, 900);
            bus(1'b1, `TPWM_IDX_CONTROL, {2'b00, p[2:0], 3'h3}, 4'h1);
            set_duty(duty);
            measure();
            measure();
            check("prescaled cycle", per, 1024 << p);
            check("prescaled active", thi[1], duty << p);
        end
        wait_irq();
        bus(1'b0, 8'h00, 8'h00, 4'h1);
        check("overflow flag set", rd[2:0], 3'h1);
        // The flag is cleared by a read of the counter, not by the read that shows it.
        bus(1'b0, `TPWM_IDX_STATUS, 8'h00, 4'h1);
        bus(1'b0, 8'h00, 8'h00, 4'h1);
        check("overflow flag cleared", rd[2:0], 3'h0);
        final_report();
    end
endmodule : test_three_phase_pwm_with_complement
